// file: logic/extended_timer_capture_compare.sv
/*
  Extended function timer: 16-bit free-running counter, two input captures,
  two output compares, one-pulse and PWM modes, overflow flag and interrupt
  source routing.
  Assumes a byte register port on sys_clk with read data one cycle later;
  capture and clock pins are asynchronous and are synchronised here.
*/
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module extended_timer_capture_compare
  import eft_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire reg_req_s   regReq,
  output logic [7:0]      regRdata,
  input  wire logic       captureInOne,
  input  wire logic       captureInTwo,
  input  wire logic       extTimerClock,
  input  wire logic [3:0] extIrqIn,
  output logic            compareOutOne,
  output logic            compareOutTwo,
  output logic            comparePinOwnOne,
  output logic            comparePinOwnTwo,
  output logic            timerIrq,
  output logic [3:0]      irqChannel
);

  irq_ctrl_s  irqCtrl_r;
  mode_ctrl_s modeCtrl_r;
  flags_s     flags_r;
  irq_sel_s   irqSel_r;
  logic [15:0] count_r;
  logic [15:0] cap1_r;
  logic [15:0] cap2_r;
  logic [15:0] cmp1_r;
  logic [15:0] cmp2_r;
  logic [2:0]  div_r;
  logic [2:0]  syncA_r;
  logic [2:0]  syncB_r;
  logic [2:0]  prev_r;
  logic [4:0]  armed_r;
  logic        pulseActive_r;
  logic        out1_r;
  logic        out2_r;
  logic [7:0]  rdata_r;

  logic tick;
  logic cap1Edge;
  logic cap2Edge;
  logic extEdge;
  logic cntLoWrite;
  logic match1;
  logic match2;
  logic wrap;
  logic modeAlt;
  logic wrIrqCtrl;
  logic [4:0] clrReq;

  // Edge of a synchronised level in the selected direction
  function automatic logic edgeSeen(input logic now, input logic prev, input logic rising);
    edgeSeen = rising ? (now & ~prev) : (~now & prev);
  endfunction

  // Register access decode
  function automatic logic hit(input reg_req_s r, input logic [7:0] a);
    hit = (r.wr | r.rd) && (r.addr == a);
  endfunction

  // Two-stage synchronisers; only the second stage and later are read.
  // Kept out of reset so they follow the pins during reset: a pin that
  // idles high then shows no false edge when reset lets go.
  always_ff @(posedge sys_clk)
  begin
    syncA_r <= {extTimerClock, captureInTwo, captureInOne};
    syncB_r <= syncA_r;
    prev_r  <= syncB_r;
  end

  assign cap1Edge = edgeSeen(syncB_r[0], prev_r[0], irqCtrl_r.captureEdgeOne);
  assign cap2Edge = edgeSeen(syncB_r[1], prev_r[1], modeCtrl_r.captureEdgeTwo);
  assign extEdge  = edgeSeen(syncB_r[2], prev_r[2], modeCtrl_r.extClockEdge);

  // Prescaler runs freely; tick is a one-cycle enable
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      div_r <= 3'h0;
    else
      div_r <= div_r + 3'h1;
  end

  always_comb
  begin
    case (modeCtrl_r.clockSelect)
      CLK_DIV4: tick = (div_r & DIV4_MASK) == DIV4_MASK;
      CLK_DIV2: tick = (div_r & DIV2_MASK) == DIV2_MASK;
      CLK_DIV8: tick = (div_r & DIV8_MASK) == DIV8_MASK;
      CLK_EXT:  tick = extEdge;
      default:  tick = 1'b0;
    endcase
  end

  assign cntLoWrite = regReq.wr &&
                      (regReq.addr == ADDR_CNT_LO || regReq.addr == ADDR_ACNT_LO);
  assign wrap       = tick && !cntLoWrite && (count_r == CNT_MAX);
  assign match1     = tick && !cntLoWrite && (count_r + 16'h0001 == cmp1_r);
  assign match2     = tick && !cntLoWrite && (count_r + 16'h0001 == cmp2_r);
  assign modeAlt    = modeCtrl_r.onePulseMode | modeCtrl_r.pwmMode;

  // Free-running counter; in PWM mode compare two ends the period
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      count_r <= CNT_RESET;
    else if (cntLoWrite)
      count_r <= CNT_RESET;
    else if (modeCtrl_r.pwmMode && match2)
      count_r <= CNT_RESET;
    else if (modeCtrl_r.onePulseMode && !pulseActive_r && cap1Edge)
      count_r <= CNT_RESET;
    else if (tick)
      count_r <= count_r + 16'h0001;
  end

  // Captures latch the counter in every mode; in one-pulse mode capture one also triggers
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cap1_r <= 16'h0000;
      cap2_r <= 16'h0000;
    end
    else
    begin
      if (cap1Edge)
        cap1_r <= count_r;
      if (cap2Edge)
        cap2_r <= count_r;
    end
  end

  // Control and compare registers written by software
  assign wrIrqCtrl = regReq.wr && regReq.addr == ADDR_IRQ_CTRL;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      irqCtrl_r  <= CTRL_RESET;
      modeCtrl_r <= CTRL_RESET;
      irqSel_r   <= SEL_RESET;
      cmp1_r     <= CMP_RESET;
      cmp2_r     <= CMP_RESET;
    end
    else if (regReq.wr)
    begin
      case (regReq.addr)
        ADDR_IRQ_CTRL:  irqCtrl_r  <= regReq.wdata;
        ADDR_MODE_CTRL: modeCtrl_r <= regReq.wdata;
        ADDR_IRQ_SEL:   irqSel_r   <= regReq.wdata[3:0];
        ADDR_CMP1_HI:   cmp1_r[15:8] <= regReq.wdata;
        ADDR_CMP1_LO:   cmp1_r[7:0]  <= regReq.wdata;
        ADDR_CMP2_HI:   cmp2_r[15:8] <= regReq.wdata;
        ADDR_CMP2_LO:   cmp2_r[7:0]  <= regReq.wdata;
        default:        ;
      endcase
    end
  end

  // Flag clear: arm on a status read, clear on a later low-byte access.
  // Order in clrReq follows flags_s: cap1, cmp1, ovf, cap2, cmp2.
  assign clrReq = {hit(regReq, ADDR_CAP1_LO), hit(regReq, ADDR_CMP1_LO),
                   hit(regReq, ADDR_CNT_LO),  hit(regReq, ADDR_CAP2_LO),
                   hit(regReq, ADDR_CMP2_LO)} & armed_r;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      armed_r <= 5'h00;
    else if (regReq.rd && regReq.addr == ADDR_FLAGS)
      armed_r <= flags_r;                   // Only flags seen set may clear
    else
      armed_r <= armed_r & ~clrReq;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      flags_r <= 5'h00;
    else
    begin
      flags_r.captureFlagOne <= cap1Edge | (flags_r.captureFlagOne & ~clrReq[4]);
      flags_r.compareFlagOne <= match1   | (flags_r.compareFlagOne & ~clrReq[3]);
      flags_r.overflowFlag   <= wrap     | (flags_r.overflowFlag   & ~clrReq[2]);
      flags_r.captureFlagTwo <= cap2Edge | (flags_r.captureFlagTwo & ~clrReq[1]);
      flags_r.compareFlagTwo <= match2   | (flags_r.compareFlagTwo & ~clrReq[0]);
    end
  end

  // One-pulse window: opened by capture one edge, closed by compare one
  always_ff @(posedge sys_clk)
  begin
    if (srst || !modeCtrl_r.onePulseMode)
      pulseActive_r <= 1'b0;
    else if (!pulseActive_r && cap1Edge)
      pulseActive_r <= 1'b1;
    else if (pulseActive_r && match1)
      pulseActive_r <= 1'b0;
  end

  // Compare output levels; force writes act in the write cycle itself
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      out1_r <= 1'b0;
      out2_r <= 1'b0;
    end
    else
    begin
      if (wrIrqCtrl && regReq.wdata[4])
        out2_r <= regReq.wdata[2];
      else if (match2 && !modeAlt)
        out2_r <= irqCtrl_r.outputLevelTwo;
      if (wrIrqCtrl && regReq.wdata[3])
        out1_r <= regReq.wdata[0];
      else if (modeCtrl_r.pwmMode && match2)
        out1_r <= irqCtrl_r.outputLevelTwo;   // Period start
      else if (modeCtrl_r.onePulseMode && !pulseActive_r && cap1Edge)
        out1_r <= irqCtrl_r.outputLevelTwo;
      else if (modeAlt && match1)
        out1_r <= ~irqCtrl_r.outputLevelTwo;
      else if (match1 && !modeAlt)
        out1_r <= irqCtrl_r.outputLevelOne;
    end
  end

  assign compareOutOne    = out1_r;
  assign compareOutTwo    = out2_r;
  // Compare logic runs regardless; only pin ownership follows the enable
  assign comparePinOwnOne = modeCtrl_r.comparePinEnableOne;
  assign comparePinOwnTwo = modeCtrl_r.comparePinEnableTwo;

  // Interrupt request holds while any enabled flag stays set
  assign timerIrq =
    (irqCtrl_r.captureIrqEnable  & (flags_r.captureFlagOne | flags_r.captureFlagTwo)) |
    (irqCtrl_r.compareIrqEnable  & (flags_r.compareFlagOne | flags_r.compareFlagTwo)) |
    (irqCtrl_r.overflowIrqEnable & flags_r.overflowFlag);

  // Channel routing: bit3 overflow, bit2 compare, bit1 capture, bit0 global
  always_comb
  begin
    irqChannel[3] = irqSel_r.overflowIrqSelect ?
                    (irqCtrl_r.overflowIrqEnable & flags_r.overflowFlag) : extIrqIn[3];
    irqChannel[2] = irqSel_r.compareIrqSelect ?
                    (irqCtrl_r.compareIrqEnable &
                     (flags_r.compareFlagOne | flags_r.compareFlagTwo)) : extIrqIn[2];
    irqChannel[1] = irqSel_r.captureIrqSelect ?
                    (irqCtrl_r.captureIrqEnable &
                     (flags_r.captureFlagOne | flags_r.captureFlagTwo)) : extIrqIn[1];
    irqChannel[0] = irqSel_r.globalTimerIrqSelect ? timerIrq : extIrqIn[0];
  end

  // Read data, one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      rdata_r <= 8'h00;
    else if (regReq.rd)
    begin
      case (regReq.addr)
        ADDR_CAP1_HI:   rdata_r <= cap1_r[15:8];
        ADDR_CAP1_LO:   rdata_r <= cap1_r[7:0];
        ADDR_CAP2_HI:   rdata_r <= cap2_r[15:8];
        ADDR_CAP2_LO:   rdata_r <= cap2_r[7:0];
        ADDR_CNT_HI,
        ADDR_ACNT_HI:   rdata_r <= count_r[15:8];
        ADDR_CNT_LO,
        ADDR_ACNT_LO:   rdata_r <= count_r[7:0];
        ADDR_CMP1_HI:   rdata_r <= cmp1_r[15:8];
        ADDR_CMP1_LO:   rdata_r <= cmp1_r[7:0];
        ADDR_CMP2_HI:   rdata_r <= cmp2_r[15:8];
        ADDR_CMP2_LO:   rdata_r <= cmp2_r[7:0];
        ADDR_IRQ_CTRL:  rdata_r <= irqCtrl_r;
        ADDR_MODE_CTRL: rdata_r <= modeCtrl_r;
        ADDR_FLAGS:     rdata_r <= {flags_r, 3'b000};
        ADDR_IRQ_SEL:   rdata_r <= {4'h0, irqSel_r};
        default:        rdata_r <= 8'h00;
      endcase
    end
    else
      rdata_r <= 8'h00;
  end

  assign regRdata = rdata_r;

endmodule // extended_timer_capture_compare

// file: logic/eft_pkg.sv
/*
  Constants, field positions and carrier types for the extended function
  timer with two captures and two compares.
  Assumes a byte-wide register port on sys_clk and pins from outside the
  clock domain.
  How it works, rule by rule, is listed below.
*/
// How it works
// - capture enable set lets either capture flag raise the timer interrupt.
// - compare enable set lets either compare flag raise the timer interrupt.
// - overflow enable set lets the overflow flag raise the timer interrupt.
// - writing a force bit copies its level bit to the pin at once.
// - compare two match with pin enabled copies level two to pin two.
// - compare one match with pin enabled copies level one to pin one.
// - in one-pulse and PWM modes level two drives pin one.
// - capture one edge: falling when select bit zero, rising when one.
// - capture two edge: falling when select bit zero, rising when one.
// - pin enable gives the pin to the timer, else it stays general I/O.
// - one-pulse mode: capture one edge starts one pulse sized by compare one.
// - PWM mode: pulse length from compare one, period from compare two.
// - clock select: 00 div4, 01 div2, 10 div8, 11 external clock.
// - external clock counts on falling edge if edge bit zero, else rising.
// - capture flag sets on capture, clears after status read then low byte access.
// - compare flag sets on match, clears after status read then low byte access.
// - overflow flag sets when the counter wraps from all ones to zero.
// - overflow clears via status read then counter low; alternate low never clears.
// - low three status bits read zero; all flags zero after reset.
// - each select bit routes its channel to timer source or external; upper read 0.
// - writing either counter low byte resets the counter.
// - capture copies the sixteen bit counter into that capture value.
package eft_pkg;
  localparam logic [7:0] ADDR_CAP1_HI   = 8'hf0;
  localparam logic [7:0] ADDR_CAP1_LO   = 8'hf1;
  localparam logic [7:0] ADDR_CAP2_HI   = 8'hf2;
  localparam logic [7:0] ADDR_CAP2_LO   = 8'hf3;
  localparam logic [7:0] ADDR_CNT_HI    = 8'hf4;
  localparam logic [7:0] ADDR_CNT_LO    = 8'hf5;
  localparam logic [7:0] ADDR_ACNT_HI   = 8'hf6;
  localparam logic [7:0] ADDR_ACNT_LO   = 8'hf7;
  localparam logic [7:0] ADDR_CMP1_HI   = 8'hf8;
  localparam logic [7:0] ADDR_CMP1_LO   = 8'hf9;
  localparam logic [7:0] ADDR_CMP2_HI   = 8'hfa;
  localparam logic [7:0] ADDR_CMP2_LO   = 8'hfb;
  localparam logic [7:0] ADDR_IRQ_CTRL  = 8'hfc;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'hfd;
  localparam logic [7:0] ADDR_FLAGS     = 8'hfe;
  localparam logic [7:0] ADDR_IRQ_SEL   = 8'hff;

  localparam logic [15:0] CNT_RESET     = 16'hfffc;
  localparam logic [15:0] CNT_MAX       = 16'hffff;
  localparam logic [15:0] CMP_RESET     = 16'h8000;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [3:0]  SEL_RESET     = 4'h0;

  // Clock select codes
  localparam logic [1:0] CLK_DIV4 = 2'b00;
  localparam logic [1:0] CLK_DIV2 = 2'b01;
  localparam logic [1:0] CLK_DIV8 = 2'b10;
  localparam logic [1:0] CLK_EXT  = 2'b11;
  localparam logic [2:0] DIV2_MASK = 3'h1;
  localparam logic [2:0] DIV4_MASK = 3'h3;
  localparam logic [2:0] DIV8_MASK = 3'h7;

  // First control register, bit 7 down to bit 0
  typedef struct packed {
    logic captureIrqEnable;
    logic compareIrqEnable;
    logic overflowIrqEnable;
    logic forceOutputTwo;
    logic forceOutputOne;
    logic outputLevelTwo;
    logic captureEdgeOne;
    logic outputLevelOne;
  } irq_ctrl_s;

  // Second control register, bit 7 down to bit 0
  typedef struct packed {
    logic       comparePinEnableOne;
    logic       comparePinEnableTwo;
    logic       onePulseMode;
    logic       pwmMode;
    logic [1:0] clockSelect;
    logic       captureEdgeTwo;
    logic       extClockEdge;
  } mode_ctrl_s;

  // Status flags, packed in status register order (bits 7..3)
  typedef struct packed {
    logic captureFlagOne;
    logic compareFlagOne;
    logic overflowFlag;
    logic captureFlagTwo;
    logic compareFlagTwo;
  } flags_s;

  // Interrupt source selection, bits 3..0
  typedef struct packed {
    logic overflowIrqSelect;
    logic compareIrqSelect;
    logic captureIrqSelect;
    logic globalTimerIrqSelect;
  } irq_sel_s;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;
endpackage

// file: dv/extended_timer_capture_compare_properties.sv
/*
  Port assertions for the timer block, bound to its top module.
  Assumes one-cycle register strobes and read data one cycle later.
*/
`timescale 1ns/1ps
module extended_timer_capture_compare_properties
  import eft_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire reg_req_s   regReq,
  input wire logic [7:0] regRdata,
  input wire logic [3:0] extIrqIn,
  input wire logic       compareOutOne,
  input wire logic       compareOutTwo,
  input wire logic       comparePinOwnOne,
  input wire logic       comparePinOwnTwo,
  input wire logic       timerIrq,
  input wire logic [3:0] irqChannel
);
  logic [7:0] ctrl_r;
  logic [7:0] mode_r;
  logic [3:0] sel_r;
  logic       wrCtrl;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // Shadow control registers; only port writes can change them
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ctrl_r <= CTRL_RESET;
      mode_r <= CTRL_RESET;
      sel_r  <= SEL_RESET;
    end
    else if (regReq.wr)
    begin
      if (regReq.addr == ADDR_IRQ_CTRL)
        ctrl_r <= regReq.wdata;
      if (regReq.addr == ADDR_MODE_CTRL)
        mode_r <= regReq.wdata;
      if (regReq.addr == ADDR_IRQ_SEL)
        sel_r <= regReq.wdata[3:0];
    end
  end
  // Alternate modes own pin one, so forcing is judged in plain mode only
  assign wrCtrl = regReq.wr && regReq.addr == ADDR_IRQ_CTRL && mode_r[5:4] == 2'b00;

  sequence s_read_flags;
    regReq.rd && regReq.addr == ADDR_FLAGS;
  endsequence
  sequence s_read_sel;
    regReq.rd && regReq.addr == ADDR_IRQ_SEL;
  endsequence

  property p_flags_low;
    s_read_flags |=> regRdata[2:0] == 3'b000;
  endproperty
  a_flags_low: assert property (p_flags_low) else $error("low flag bits set");
  property p_sel_read;
    s_read_sel |=> regRdata == {4'h0, sel_r};
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("select readback");
  property p_route;
    (irqChannel & ~sel_r) == (extIrqIn & ~sel_r) && (!sel_r[0] || irqChannel[0] == timerIrq);
  endproperty
  a_route: assert property (p_route) else $error("irq routing");
  property p_irq_off;
    ctrl_r[7:5] == 3'b000 |-> !timerIrq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  property p_irq_hold;
    timerIrq && !regReq.wr && !regReq.rd |=> timerIrq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  property p_force_one;
    wrCtrl && regReq.wdata[3] |=> compareOutOne == $past(regReq.wdata[0]);
  endproperty
  a_force_one: assert property (p_force_one) else $error("force one");
  property p_force_two;
    wrCtrl && regReq.wdata[4] |=> compareOutTwo == $past(regReq.wdata[2]);
  endproperty
  a_force_two: assert property (p_force_two) else $error("force two");
  property p_pin_own;
    comparePinOwnOne == mode_r[7] && comparePinOwnTwo == mode_r[6];
  endproperty
  a_pin_own: assert property (p_pin_own) else $error("pin ownership");
endmodule // extended_timer_capture_compare_properties

bind extended_timer_capture_compare extended_timer_capture_compare_properties props
(
  .sys_clk, .srst, .regReq, .regRdata, .extIrqIn, .compareOutOne, .compareOutTwo,
  .comparePinOwnOne, .comparePinOwnTwo, .timerIrq, .irqChannel
);

// file: dv/eft_pin_partner.sv
/*
  Far-side pin model: capture inputs and external timer clock.
  Assumes the bench sets capture levels and gates the clock.
*/
`timescale 1ns/1ps
module eft_pin_partner
(
  input  wire logic       extRun,
  input  wire logic [1:0] capLevel,
  output logic            captureInOne,
  output logic            captureInTwo,
  output logic            extTimerClock
);
  // Pins move a little after the request, off the sampling edge
  assign #7 captureInOne = capLevel[0];
  assign #7 captureInTwo = capLevel[1];

  // Unrelated period, slow enough for the synchroniser; still when not gated
  initial
  begin
    extTimerClock = 1'b0;
    forever
    begin
      #365;
      if (extRun)
        extTimerClock = ~extTimerClock;
    end
  end
endmodule // eft_pin_partner

// file: dv/extended_timer_capture_compare_tb_top.sv
/*
  Self-checking bench: register port driver, pin partner, scenario tasks.
  Assumes the checker binds itself to the design.
*/
`timescale 1ns/1ps
module extended_timer_capture_compare_tb_top
  import eft_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       srst = 1'b1;
  reg_req_s   regReq = '0;
  logic [7:0] regRdata;
  logic [3:0] extIrqIn = 4'h5;
  logic       extRun = 1'b0;
  logic [1:0] capLevel = 2'b00;
  logic       captureInOne, captureInTwo, extTimerClock, timerIrq;
  logic       compareOutOne, compareOutTwo, comparePinOwnOne, comparePinOwnTwo;
  logic [3:0] irqChannel;
  int         errors = 0;
  int         check_count = 0;
  int         cycles = 0;

  extended_timer_capture_compare DUT (.sys_clk, .srst, .regReq, .regRdata, .captureInOne,
    .captureInTwo, .extTimerClock, .extIrqIn, .compareOutOne, .compareOutTwo,
    .comparePinOwnOne, .comparePinOwnTwo, .timerIrq, .irqChannel);
  eft_pin_partner partner (.extRun, .capLevel, .captureInOne, .captureInTwo, .extTimerClock);

  // 50 ns clock; the cycle ceiling cuts a hang short
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Strobe held for one edge, then a quiet edge so strobes never clash
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    regReq.wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    regReq.rd <= 1'b0;
    #1 d = regRdata;
    @(posedge sys_clk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d & m, e);
  endtask

  task automatic t_reset();
    rc(ADDR_FLAGS, 8'hff, 8'h00);
    for (int a = 8'hf0; a <= 8'hff; a++)
      if ((a < 8'hf4 || a > 8'hf7) && a != 8'hfe)
        rc(8'(a), 8'hff, (a == 8'hf8 || a == 8'hfa) ? 8'h80 : 8'h00);
  endtask

  task automatic t_regs();
    wr(ADDR_IRQ_SEL, 8'hff);
    rc(ADDR_IRQ_SEL, 8'hff, 8'h0f);
    wr(ADDR_FLAGS, 8'hff);
    rc(ADDR_FLAGS, 8'hdf, 8'h00);
    rc(8'h10, 8'hff, 8'h00);
    wr(ADDR_CMP1_HI, 8'h5a);
    rc(ADDR_CMP1_HI, 8'hff, 8'h5a);
    wr(ADDR_IRQ_CTRL, 8'h1d);
    chk(8'({compareOutTwo, compareOutOne}), 8'h03);
    wr(ADDR_IRQ_CTRL, 8'h18);
    chk(8'({compareOutTwo, compareOutOne}), 8'h00);
  endtask

  // Wrap from the loaded value must fall between three and four divided ticks
  task automatic t_clock();
    logic [7:0] d;
    int         div [3] = '{4, 2, 8};
    logic [1:0] code [3] = '{CLK_DIV4, CLK_DIV2, CLK_DIV8};
    wr(ADDR_IRQ_CTRL, 8'h20);
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_MODE_CTRL, {4'h0, code[i], 2'b00});
      rd(ADDR_FLAGS, d);
      wr(ADDR_CNT_LO, 8'h00);
      repeat (3 * div[i] - 3) @(posedge sys_clk);
      rc(ADDR_FLAGS, 8'h20, 8'h00);
      repeat (div[i] + 4) @(posedge sys_clk);
      rc(ADDR_FLAGS, 8'h20, 8'h20);
      chk(8'(timerIrq), 8'h01);
      rd(ADDR_ACNT_LO, d);
      rc(ADDR_FLAGS, 8'h20, 8'h20);
      rd(ADDR_CNT_LO, d);
      rc(ADDR_FLAGS, 8'h20, 8'h00);
      chk(8'(timerIrq), 8'h00);
    end
  endtask

  // External clock held still, so captures see the loaded counter value
  task automatic t_capture();
    logic [7:0] d;
    wr(ADDR_MODE_CTRL, 8'h0f);
    wr(ADDR_IRQ_CTRL, 8'h82);
    wr(ADDR_CNT_LO, 8'h00);
    rc(ADDR_CNT_HI, 8'hff, 8'hff);
    rc(ADDR_ACNT_LO, 8'hff, 8'hfc);
    capLevel <= 2'b11;
    repeat (8) @(posedge sys_clk);
    rc(ADDR_CAP1_LO, 8'hff, 8'hfc);
    rc(ADDR_FLAGS, 8'h90, 8'h90);
    chk(8'(timerIrq), 8'h01);
    rc(ADDR_CAP1_HI, 8'hff, 8'hff);
    rc(ADDR_CAP1_LO, 8'hff, 8'hfc);
    rc(ADDR_CAP2_HI, 8'hff, 8'hff);
    rc(ADDR_CAP2_LO, 8'hff, 8'hfc);
    rc(ADDR_FLAGS, 8'h90, 8'h00);
    chk(8'(timerIrq), 8'h00);
    wr(ADDR_IRQ_CTRL, 8'h80);
    wr(ADDR_MODE_CTRL, 8'h0d);
    capLevel <= 2'b00;
    repeat (8) @(posedge sys_clk);
    rc(ADDR_FLAGS, 8'h90, 8'h90);
    rd(ADDR_CAP1_LO, d);
    rd(ADDR_CAP2_LO, d);
  endtask

  task automatic t_compare();
    logic [7:0] d;
    wr(ADDR_CMP1_HI, 8'hff);
    wr(ADDR_CMP1_LO, 8'hfe);
    wr(ADDR_CMP2_HI, 8'hff);
    wr(ADDR_CMP2_LO, 8'hff);
    wr(ADDR_IRQ_CTRL, 8'h45);
    wr(ADDR_MODE_CTRL, 8'hcd);
    wr(ADDR_CNT_LO, 8'h00);
    extRun <= 1'b1;
    repeat (60) @(posedge sys_clk);
    extRun <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk(8'({compareOutTwo, compareOutOne}), 8'h03);
    chk(8'({comparePinOwnTwo, comparePinOwnOne}), 8'h03);
    rc(ADDR_FLAGS, 8'h48, 8'h48);
    chk(8'(timerIrq), 8'h01);
    rd(ADDR_CMP1_LO, d);
    wr(ADDR_CMP2_LO, 8'hff);
    rc(ADDR_FLAGS, 8'h48, 8'h00);
    chk(8'(timerIrq), 8'h00);
    wr(ADDR_MODE_CTRL, 8'h0d);
    chk(8'({comparePinOwnTwo, comparePinOwnOne}), 8'h00);
  endtask

  // PWM, then one-pulse, on the divide-by-2 tick; level two drives pin one.
  // PWM period is five ticks, high for two, so 40 cycles hold 16 high ones.
  task automatic t_modes();
    int hi;
    wr(ADDR_CMP1_HI, 8'hff);
    wr(ADDR_CMP1_LO, 8'hfe);
    wr(ADDR_CMP2_HI, 8'h00);
    wr(ADDR_CMP2_LO, 8'h01);
    wr(ADDR_IRQ_CTRL, 8'h18);
    wr(ADDR_IRQ_CTRL, 8'h06);
    wr(ADDR_MODE_CTRL, 8'h14);
    wr(ADDR_CNT_LO, 8'h00);
    repeat (20) @(posedge sys_clk);
    hi = 0;
    repeat (40)
    begin
      @(posedge sys_clk);
      hi += compareOutOne;
    end
    chk(8'(hi), 8'h10);
    chk(8'(compareOutTwo), 8'h00);
    // Pulse phase against the free prescaler gives three or four cycles
    wr(ADDR_MODE_CTRL, 8'h24);
    wr(ADDR_IRQ_CTRL, 8'h0e);
    capLevel <= 2'b01;
    hi = 0;
    repeat (20)
    begin
      @(posedge sys_clk);
      hi += compareOutOne;
    end
    chk(8'(hi >= 3 && hi <= 4), 8'h01);
    chk(8'(compareOutOne), 8'h00);
  endtask

  // Main sequence: reset for 20 cycles, then the scenarios in turn
  initial
  begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_regs();
    t_clock();
    t_capture();
    t_compare();
    t_modes();
    results();
  end
endmodule // extended_timer_capture_compare_tb_top
